/* File: shared/pmc_pkg.sv */
// Constants, types and states of the power mode and domain controller
package pmc_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    // Wait after a domain switch closes before isolation is released
    localparam int PWR_SETTLE_NS = 200;
    localparam int PWR_SETTLE_CYC = (PWR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Length of the hardware reset raised on a reset-on-wake
    localparam int HW_RST_HOLD_NS = 1000;
    localparam int HW_RST_HOLD_CYC = (HW_RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Domain indices of the gated switch array
    // ------------------------------------------------------------
    localparam int DOM_SYS = 0;
    localparam int DOM_PER = 1;
    localparam int DOM_DBG = 2;
    localparam int DOM_RAD = 3;
    localparam int DOM_RR1 = 4;
    localparam int DOM_RR2 = 5;
    localparam int DOM_RR3 = 6;
    localparam int DOM_RR4 = 7;
    localparam int DOM_SR = 8;
    localparam int DOM_NUM = 9;

    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int DEEP_SLEEP_BIT_POS = 2;
    localparam int CPU_SCR_W = 8;
    localparam int RADIO_RET_W = 11;
    localparam int EXCHANGE_MEMORY_MAP_W = 4;
    localparam int OTP_WC_W = 14;
    localparam logic [OTP_WC_W-1:0] OTP_WC_RESET = 14'h0000;

    // Software-programmed domain switches
    typedef struct packed {
        logic per;
        logic rad;
        logic [3:0] rr;
    } pmc_dom_en_t;

    // Register fields kept alive across gated sleep
    typedef struct packed {
        logic [RADIO_RET_W-1:0] radio_ctrl;
        logic debug_freeze_enable;
        logic [EXCHANGE_MEMORY_MAP_W-1:0] exchange_memory_map;
    } pmc_ret_t;

    localparam pmc_ret_t RET_RESET = '0;

    // Controller states, Gray coded from active through gate-off, gated and wake-on to mirror
    typedef enum logic [2:0] {
        ST_ACTIVE = 3'b000,
        ST_GATE_OFF = 3'b001,
        ST_GATED = 3'b011,
        ST_WAKE_ON = 3'b010,
        ST_MIRROR = 3'b110,
        ST_HW_RESET = 3'b111,
        ST_SLEEP = 3'b100
    } pmc_state_t;

endpackage : pmc_pkg

/* File: hw/pmc_dom_switch.sv */
// One gated power domain: switch enable and isolation sequencing
`timescale 1ns/10ps
module pmc_dom_switch
    import pmc_pkg::*;
#(
    parameter int SETTLE_CYC = PWR_SETTLE_CYC
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic on_req_in,
    output logic pwr_en_out,
    output logic iso_out,
    output logic busy_out
);

    localparam int CW = $clog2(SETTLE_CYC + 1);
    logic [CW-1:0] cnt;

    // ------------------------------------------------------------
    // Isolate before cutting power, release only once stable
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pwr_en_out <= 1'b1;
            iso_out <= 1'b0;
            cnt <= '0;
        end else if (on_req_in && !pwr_en_out) begin
            pwr_en_out <= 1'b1; // Iso stays high while it powers up
            cnt <= CW'(SETTLE_CYC - 1);
        end else if (on_req_in && iso_out) begin
            if (cnt == '0) begin
                iso_out <= 1'b0;
            end else begin
                cnt <= cnt - 1'b1;
            end
        end else if (!on_req_in && pwr_en_out && !iso_out) begin
            iso_out <= 1'b1;
        end else if (!on_req_in && pwr_en_out) begin
            pwr_en_out <= 1'b0;
        end
    end

    // Domain has not yet reached what is requested
    assign busy_out = on_req_in ? (!pwr_en_out || iso_out) : pwr_en_out;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    iso_before_off_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        $fell(pwr_en_out) |-> $past(iso_out))
        else $error("domain power removed without isolation");
    iso_release_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        $fell(iso_out) |-> pwr_en_out && $past(pwr_en_out) && $past(cnt) == '0)
        else $error("isolation released before domain settled");

endmodule : pmc_dom_switch

/* File: hw/pmc_ctrl.sv */
// Power mode and power domain controller top level
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Functional notes
// - Active mode keeps every needed domain on, no gating.
// - Plain sleep gates nothing; system on, peripheral and radio as set.
// - Extended sleep keeps always-on, enabled retention banks, system RAM; peripheral and radio as set.
// - Deep sleep keeps always-on and enabled retention banks; peripheral and radio as set.
// - Wake from deep sleep mirrors OTP into RAM unless reset-on-wake is set; extended skips it.
// - Gated sleep turns system and debug off; system RAM on only extended.
// - Gated sleep switches off bandgap, DC-DC, oscillators, ADC, regulators.
// - Always-on domain stays powered at all times.
// - System domain is powered in every state except gate-off and gated sleep, also during wake, mirror and reset.
// - Peripheral domain can be switched off when its work is done.
// - Separate domains gate debug logic and radio digital with link core.
// - Four retention banks of 2, 3, 2 and 1 kB switch independently.
// - System-RAM domain powers only the 42 kB RAM, retained not accessible.
// - Retention keeps radio control fields, debug freeze and memory map.
// - OTP copy word count keeps its value through every sleep.
// - All always-on range registers keep contents through all sleeps.
// - Peripheral range registers are lost when peripheral domain is off.
// - Wake skips boot code; a hardware sequencer copies using retained count.
// - Reset-on-wake raises hardware reset when waking from gated sleep.
// ----------------------------------------------------------------
module pmc_ctrl
    import pmc_pkg::*;
#(
    parameter int SETTLE_CYC = PWR_SETTLE_CYC,
    parameter int RST_HOLD_CYC = HW_RST_HOLD_CYC
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic cpu_sleeping_in,
    input wire logic [CPU_SCR_W-1:0] cpu_sleep_control_register_in,
    input wire logic keep_sysram_bit_in,
    input wire logic reset_after_wake_bit_in,
    input wire logic wake_event_in,
    input wire pmc_dom_en_t dom_enable_in,
    input wire logic ret_wr_in,
    input wire pmc_ret_t ret_data_in,
    input wire logic otp_wc_wr_in,
    input wire logic [OTP_WC_W-1:0] otp_wc_data_in,
    input wire logic copy_ack_in,
    output pmc_state_t mode_out,
    output logic always_on_domain_out,
    output logic [DOM_NUM-1:0] dom_pwr_out,
    output logic [DOM_NUM-1:0] dom_iso_out,
    output logic analog_en_out,
    output logic cpu_run_out,
    output logic hw_reset_out,
    output logic per_regs_clear_out,
    output pmc_ret_t ret_fields_out,
    output logic [OTP_WC_W-1:0] otp_copy_word_count_out,
    output logic copy_req_out,
    output logic [OTP_WC_W-1:0] copy_addr_out
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam int RCW = $clog2(RST_HOLD_CYC + 1);

    pmc_state_t state;
    pmc_state_t next_state;
    logic mode_ext;
    logic deep_req;
    logic [DOM_NUM-1:0] dom_req;
    logic [DOM_NUM-1:0] dom_busy;
    logic all_settled;
    logic [RCW-1:0] rst_cnt;
    logic copy_last;
    logic cpu_domains_on;

    // Gated sleep request: processor asleep with its deep-sleep bit set
    assign deep_req = cpu_sleeping_in &&
        cpu_sleep_control_register_in[DEEP_SLEEP_BIT_POS];
    assign all_settled = ~|dom_busy;
    assign copy_last = copy_ack_in && (copy_addr_out == otp_copy_word_count_out - 1'b1);

    // ------------------------------------------------------------
    // Mode sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ST_ACTIVE: begin
                if (deep_req) begin
                    next_state = ST_GATE_OFF;
                end else if (cpu_sleeping_in) begin
                    next_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (deep_req) begin
                    next_state = ST_GATE_OFF;
                end else if (wake_event_in || !cpu_sleeping_in) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_GATE_OFF: begin
                if (all_settled) begin
                    next_state = ST_GATED;
                end
            end
            ST_GATED: begin
                if (wake_event_in) begin
                    next_state = reset_after_wake_bit_in ? ST_HW_RESET : ST_WAKE_ON;
                end
            end
            ST_WAKE_ON: begin
                if (all_settled) begin
                    // Deep sleep lost RAM, so mirror; extended kept it
                    next_state = mode_ext ? ST_ACTIVE : ST_MIRROR;
                end
            end
            ST_MIRROR: begin
                if (otp_copy_word_count_out == '0 || copy_last) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_HW_RESET: begin
                if (rst_cnt == '0 && all_settled) begin
                    next_state = ST_ACTIVE;
                end
            end
            default: begin
                next_state = ST_ACTIVE;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= ST_ACTIVE;
        end else begin
            state <= next_state;
        end
    end

    assign mode_out = state;

    // Gated mode flavour, caught from keep-sysram at sleep entry
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mode_ext <= 1'b0;
        end else if (next_state == ST_GATE_OFF && state != ST_GATE_OFF) begin
            mode_ext <= keep_sysram_bit_in;
        end
    end

    // ------------------------------------------------------------
    // Domain requests
    // ------------------------------------------------------------
    // Processor side domains stay on outside the gated states
    assign cpu_domains_on = !(state == ST_GATE_OFF || state == ST_GATED);

    always_comb begin
        dom_req = '0;
        dom_req[DOM_SYS] = cpu_domains_on;
        dom_req[DOM_DBG] = cpu_domains_on;
        // Firmware owns these switches in every mode
        dom_req[DOM_PER] = dom_enable_in.per;
        dom_req[DOM_RAD] = dom_enable_in.rad;
        dom_req[DOM_RR4:DOM_RR1] = dom_enable_in.rr;
        // System RAM survives only extended sleep
        dom_req[DOM_SR] = cpu_domains_on || mode_ext;
    end

    // One switch with isolation per gated domain
    for (genvar d = 0; d < DOM_NUM; d++) begin : g_dom
        pmc_dom_switch #(
            .SETTLE_CYC(SETTLE_CYC)
        ) u_sw (
            .ref_clk_in(ref_clk_in),
            .rst_in(rst_in),
            .on_req_in(dom_req[d]),
            .pwr_en_out(dom_pwr_out[d]),
            .iso_out(dom_iso_out[d]),
            .busy_out(dom_busy[d])
        );
    end

    // ------------------------------------------------------------
    // Always-on, analog, processor and reset outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            always_on_domain_out <= 1'b1;
        end else begin
            always_on_domain_out <= 1'b1; // Never gated
        end
    end

    // Analog blocks drop once the gated domains are down
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            analog_en_out <= 1'b1;
        end else begin
            analog_en_out <= (next_state != ST_GATED);
        end
    end

    // Processor released only in active and plain sleep modes
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cpu_run_out <= 1'b1;
        end else begin
            cpu_run_out <= (next_state == ST_ACTIVE || next_state == ST_SLEEP);
        end
    end

    // Hardware reset pulse for a reset-on-wake
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hw_reset_out <= 1'b0;
            rst_cnt <= '0;
        end else if (state == ST_GATED && next_state == ST_HW_RESET) begin
            hw_reset_out <= 1'b1;
            rst_cnt <= RCW'(RST_HOLD_CYC - 1);
        end else if (state == ST_HW_RESET && rst_cnt != '0) begin
            rst_cnt <= rst_cnt - 1'b1;
        end else begin
            hw_reset_out <= 1'b0;
        end
    end

    // Peripheral registers cleared while their domain is unpowered
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            per_regs_clear_out <= 1'b0;
        end else begin
            per_regs_clear_out <= !dom_pwr_out[DOM_PER];
        end
    end

    // ------------------------------------------------------------
    // Retained registers, held in the always-on domain
    // ------------------------------------------------------------
    // Only the listed fields live here; others reset with their domain
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ret_fields_out <= RET_RESET;
        end else if (ret_wr_in && cpu_run_out) begin
            ret_fields_out <= ret_data_in;
        end
    end

    // Word count for the wake mirror, kept through every sleep
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            otp_copy_word_count_out <= OTP_WC_RESET;
        end else if (otp_wc_wr_in && cpu_run_out) begin
            otp_copy_word_count_out <= otp_wc_data_in;
        end
    end

    // ------------------------------------------------------------
    // Wake mirror sequencer
    // ------------------------------------------------------------
    // Request held high through the whole mirror, address steps on each acknowledge
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            copy_req_out <= 1'b0;
            copy_addr_out <= '0;
        end else if (next_state == ST_MIRROR) begin
            copy_req_out <= 1'b1;
            if (state == ST_MIRROR && copy_ack_in) begin
                copy_addr_out <= copy_addr_out + 1'b1;
            end
        end else begin
            copy_req_out <= 1'b0;
            copy_addr_out <= '0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    active_all_on_a: assert property (
        state == ST_ACTIVE && all_settled |->
        dom_pwr_out[DOM_SYS] && dom_pwr_out[DOM_SR] && !dom_iso_out[DOM_SYS])
        else $error("active mode with system domains gated");
    sleep_sys_on_a: assert property (
        state == ST_SLEEP |-> dom_pwr_out[DOM_SYS] && analog_en_out)
        else $error("plain sleep gated the system domain");
    ext_keeps_sr_a: assert property (
        state == ST_GATED && mode_ext |->
        dom_pwr_out[DOM_SR] && !dom_pwr_out[DOM_SYS] && !dom_pwr_out[DOM_DBG])
        else $error("extended sleep domain state wrong");
    deep_drops_sr_a: assert property (
        state == ST_GATED && !mode_ext |-> !dom_pwr_out[DOM_SR] && !dom_pwr_out[DOM_SYS])
        else $error("deep sleep left system RAM powered");
    mirror_deep_a: assert property (
        $rose(copy_req_out) |-> !mode_ext && $past(state) == ST_WAKE_ON)
        else $error("mirror started outside deep sleep wake");
    ext_no_mirror_a: assert property (
        state == ST_WAKE_ON && all_settled && mode_ext |=> state == ST_ACTIVE && !copy_req_out)
        else $error("extended sleep wake did not skip mirror");
    analog_off_a: assert property (
        state == ST_GATED |-> !analog_en_out)
        else $error("analog still on in gated sleep");
    aon_on_a: assert property (
        always_on_domain_out)
        else $error("always-on domain dropped");
    per_clear_a: assert property (
        !dom_pwr_out[DOM_PER] |=> per_regs_clear_out)
        else $error("peripheral registers not cleared");
    hw_reset_hold_a: assert property (
        $rose(hw_reset_out) |-> hw_reset_out[*8])
        else $error("wake reset pulse too short");
    wc_kept_a: assert property (
        state == ST_GATED |=> $stable(otp_copy_word_count_out))
        else $error("word count changed during sleep");

    // Gated-sleep processor check, then invariants that hold in every mode
    gated_cpu_off_a: assert property (
        state == ST_GATED |-> !cpu_run_out && !dom_pwr_out[DOM_DBG])
        else $error("processor side still live in gated sleep");
    iso_when_off_a: assert property (
        &(dom_iso_out | dom_pwr_out))
        else $error("unpowered domain left without isolation");
    ret_kept_a: assert property (
        !cpu_run_out |=> $stable(ret_fields_out))
        else $error("retained fields changed while processor off");
    copy_addr_range_a: assert property (
        copy_req_out && otp_copy_word_count_out != '0 |-> copy_addr_out < otp_copy_word_count_out)
        else $error("mirror address beyond word count");
    wake_reset_src_a: assert property (
        $rose(hw_reset_out) |-> $past(state) == ST_GATED && $past(reset_after_wake_bit_in))
        else $error("hardware reset raised outside a gated wake");

    ext_entry_c: cover property (state == ST_GATE_OFF && mode_ext ##[1:100] state == ST_GATED);
    deep_mirror_c: cover property (state == ST_MIRROR ##1 state == ST_ACTIVE);
    wake_reset_c: cover property ($rose(hw_reset_out));
    plain_sleep_c: cover property (state == ST_SLEEP ##1 state == ST_ACTIVE);
    ext_wake_c: cover property (state == ST_WAKE_ON && mode_ext ##1 state == ST_ACTIVE);

endmodule : pmc_ctrl

/* File: verif/pmc_cpu_model.sv */
// Processor and copy engine model: sleep requests and OTP copy acknowledges
`timescale 1ns/10ps
module pmc_cpu_model
    import pmc_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic cpu_run_in,
    input wire logic sleep_req_in,
    input wire logic deep_in,
    input wire logic keep_in,
    input wire logic slow_in,
    input wire logic copy_req_in,
    input wire logic [OTP_WC_W-1:0] words_in,
    output logic cpu_sleeping_out,
    output logic [CPU_SCR_W-1:0] scr_out,
    output logic keep_sysram_out,
    output logic copy_ack_out
);
    logic armed;
    logic done;
    logic [1:0] div;
    logic [OTP_WC_W-1:0] acks;

    // ------------------------------------------------------------
    // Sleep entry: keep bit first, deep-sleep request one cycle later
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cpu_sleeping_out <= 1'b0;
            scr_out <= 8'h00;
            keep_sysram_out <= 1'b0;
            armed <= 1'b0;
            done <= 1'b0;
        end else if (!sleep_req_in) begin
            cpu_sleeping_out <= 1'b0;
            scr_out <= 8'h00;
            keep_sysram_out <= 1'b0;
            armed <= 1'b0;
            done <= 1'b0;
        end else if (!cpu_run_in) begin
            cpu_sleeping_out <= 1'b0; // Core halted, request already taken
            scr_out <= 8'h00;
            done <= 1'b1;
        end else if (!done && !armed) begin
            keep_sysram_out <= keep_in;
            armed <= 1'b1;
        end else if (!done) begin
            cpu_sleeping_out <= 1'b1;
            scr_out <= deep_in ? 8'h04 : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Copy engine: one ack per word, only while a copy is requested
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            div <= 2'h0;
            acks <= '0;
            copy_ack_out <= 1'b0;
        end else begin
            div <= div + 2'h1;
            if (!copy_req_in) begin
                acks <= '0;
                copy_ack_out <= 1'b0;
            end else if (acks < words_in && (!slow_in || div == 2'h3)) begin
                copy_ack_out <= 1'b1;
                acks <= acks + 14'h0001;
            end else begin
                copy_ack_out <= 1'b0;
            end
        end
    end
endmodule : pmc_cpu_model

/* File: verif/tb.sv */
// Self-checking testbench of the power mode and domain controller
`timescale 1ns/10ps
module tb;
    import pmc_pkg::*;
    localparam int HOLD = 8;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic sleeping, keep, raw = 1'b0, wake = 1'b0, ret_wr = 1'b0, wc_wr = 1'b0, ack;
    logic sleep_req = 1'b0, deep = 1'b0, keep_req = 1'b0, slow = 1'b0;
    logic [CPU_SCR_W-1:0] scr;
    pmc_dom_en_t dom_en = 6'h3f;
    pmc_ret_t ret_data = '0, ret_q, rv;
    logic [OTP_WC_W-1:0] wc_data = '0, wc_q, caddr, wc;
    pmc_state_t mode;
    logic aon, analog, run, hwr, perclr, creq;
    logic [DOM_NUM-1:0] pwr, iso;
    int fail_count = 0;
    int tests_run = 0;
    int n_req, n_ack, n_hw, k;
    logic [1:0] kind;

    always #4 ref_clk_in = ~ref_clk_in;

    pmc_ctrl #(.SETTLE_CYC(2), .RST_HOLD_CYC(HOLD)) uut (.ref_clk_in(ref_clk_in),
        .rst_in(rst_in), .cpu_sleeping_in(sleeping), .cpu_sleep_control_register_in(scr),
        .keep_sysram_bit_in(keep), .reset_after_wake_bit_in(raw), .wake_event_in(wake),
        .dom_enable_in(dom_en), .ret_wr_in(ret_wr), .ret_data_in(ret_data),
        .otp_wc_wr_in(wc_wr), .otp_wc_data_in(wc_data), .copy_ack_in(ack), .mode_out(mode),
        .always_on_domain_out(aon), .dom_pwr_out(pwr), .dom_iso_out(iso),
        .analog_en_out(analog), .cpu_run_out(run), .hw_reset_out(hwr),
        .per_regs_clear_out(perclr), .ret_fields_out(ret_q), .otp_copy_word_count_out(wc_q),
        .copy_req_out(creq), .copy_addr_out(caddr));

    pmc_cpu_model u_cpu (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .cpu_run_in(run),
        .sleep_req_in(sleep_req), .deep_in(deep), .keep_in(keep_req), .slow_in(slow),
        .copy_req_in(creq), .words_in(wc_q), .cpu_sleeping_out(sleeping), .scr_out(scr),
        .keep_sysram_out(keep), .copy_ack_out(ack));

    // ------------------------------------------------------------
    // Comparison, expectation and closing helpers
    // ------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task end_of_test;
        $display("fail_count=%0d tests_run=%0d", fail_count, tests_run);
        if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    // Power expected per domain from mode kind and firmware switches
    function logic [DOM_NUM-1:0] exp_pwr(input logic gated, input logic keep_ram);
        logic [DOM_NUM-1:0] p;
        p = '0;
        p[DOM_SYS] = !gated;
        p[DOM_DBG] = !gated;
        p[DOM_SR] = !gated || keep_ram;
        p[DOM_PER] = dom_en.per;
        p[DOM_RAD] = dom_en.rad;
        p[DOM_RR4:DOM_RR1] = dom_en.rr;
        return p;
    endfunction : exp_pwr

    task wait_mode(input pmc_state_t m);
        k = 0;
        while (mode !== m && k < 300) begin
            @(negedge ref_clk_in);
            k++;
        end
        check(32'(mode), 32'(m));
    endtask : wait_mode

    // Settled domain state, isolation the inverse of power
    task check_doms(input logic gated, input logic keep_ram);
        logic [DOM_NUM-1:0] e;
        logic [DOM_NUM-1:0] ne;
        repeat (8) @(negedge ref_clk_in);
        e = exp_pwr(gated, keep_ram);
        ne = ~e;
        check(32'(pwr), 32'(e));
        check(32'(iso), 32'(ne));
        check(32'(aon), 32'h1);
        check(32'(analog), 32'(!gated));
        check(32'(run), 32'(!gated));
        check(32'(perclr), 32'(!dom_en.per));
    endtask : check_doms

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(42));
        repeat (10) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        repeat (2) @(negedge ref_clk_in);
        check(32'(mode), 32'(ST_ACTIVE));
        check(32'(pwr), 32'h1ff);
        check(32'(ret_q), 32'h0);
        check(32'(wc_q), 32'h0);
        check(32'({hwr, creq}), 32'h0);
        // Plain sleep with random firmware switches
        @(posedge ref_clk_in);
        dom_en <= pmc_dom_en_t'(6'($urandom));
        sleep_req <= 1'b1;
        wait_mode(ST_SLEEP);
        check_doms(1'b0, 1'b1);
        // Interrupt takes plain sleep back to active
        @(posedge ref_clk_in);
        wake <= 1'b1;
        @(posedge ref_clk_in);
        wake <= 1'b0;
        @(negedge ref_clk_in);
        check(32'(mode), 32'(ST_ACTIVE));
        @(posedge ref_clk_in);
        sleep_req <= 1'b0;
        wait_mode(ST_ACTIVE);
        // Gated sleeps: extended or deep, with or without reset on wake
        for (int it = 0; it < 10; it++) begin
            kind = (it < 5) ? 2'(it) : 2'($urandom);
            wc = (it < 2) ? 14'(it) : 14'(($urandom % 6) + 1);
            rv = pmc_ret_t'(16'($urandom));
            @(posedge ref_clk_in);
            ret_wr <= 1'b1;
            ret_data <= rv;
            wc_wr <= 1'b1;
            wc_data <= wc;
            dom_en <= pmc_dom_en_t'(6'($urandom));
            @(posedge ref_clk_in);
            ret_wr <= 1'b0;
            wc_wr <= 1'b0;
            keep_req <= kind[0];
            raw <= kind[1];
            deep <= 1'b1;
            slow <= 1'($urandom);
            sleep_req <= 1'b1;
            @(negedge ref_clk_in);
            check(32'(ret_q), 32'(rv));
            check(32'(wc_q), 32'(wc));
            wait_mode(ST_GATED);
            check_doms(1'b1, kind[0]);
            // Writes while the processor is off must be ignored
            @(posedge ref_clk_in);
            ret_wr <= 1'b1;
            ret_data <= ~rv;
            wc_wr <= 1'b1;
            wc_data <= ~wc;
            @(posedge ref_clk_in);
            ret_wr <= 1'b0;
            wc_wr <= 1'b0;
            wake <= 1'b1;
            @(posedge ref_clk_in);
            wake <= 1'b0;
            n_req = 0;
            n_ack = 0;
            n_hw = 0;
            k = 0;
            while (mode !== ST_ACTIVE && k < 2000) begin
                @(negedge ref_clk_in);
                k++;
                if (hwr === 1'b1) n_hw++;
                if (creq === 1'b1) n_req++;
                if (creq === 1'b1 && ack === 1'b1) begin
                    check(32'(caddr), 32'(n_ack));
                    n_ack++;
                end
            end
            check(32'(k < 2000), 32'h1);
            check(32'(n_ack), (kind == 2'b00) ? 32'(wc) : 32'h0);
            check(32'(n_req != 0), 32'(kind == 2'b00));
            check(32'(n_hw != 0), 32'(kind[1]));
            check(32'(n_hw >= HOLD || !kind[1]), 32'h1);
            check(32'(ret_q), 32'(rv));
            check(32'(wc_q), 32'(wc));
            check_doms(1'b0, 1'b1);
            @(posedge ref_clk_in);
            sleep_req <= 1'b0;
            repeat (4) @(posedge ref_clk_in);
        end
        end_of_test();
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (30000) @(posedge ref_clk_in);
        fail_count++;
        end_of_test();
    end
endmodule : tb
